// >>> tbdci_defs.svh
`ifndef TBDCI_DEFS_SVH
`define TBDCI_DEFS_SVH

// register byte offsets
`define TBDCI_REG_CTRL      4'h0
`define TBDCI_REG_MODSTAT   4'h4
`define TBDCI_REG_DEMOD_RB  4'h8
`define TBDCI_REG_DEMOD_G   4'hc

// control register fields
`define TBDCI_CTRL_SEL_LSB  0
`define TBDCI_CTRL_SEL_MSB  15
`define TBDCI_CTRL_RST      16'h3434

// status register fields
`define TBDCI_STAT_ACC_LSB  0
`define TBDCI_STAT_CODE_LSB 16
`define TBDCI_STAT_BLK_BIT  20

// weight words and integrator levels
`define TBDCI_MOD_SEL       16'h3434
`define TBDCI_REF_LEVEL     9'h100
`define TBDCI_MIN_LEVEL     9'h001
`define TBDCI_MAX_LEVEL     9'h1ff
`define TBDCI_ZERO_CODE     3'h4

// loop timing
`define TBDCI_LOOP_NS       80
`define TBDCI_CLK_NS        50
`define TBDCI_LOOP_CYC \
   (((`TBDCI_LOOP_NS / `TBDCI_CLK_NS) < 1) ? 1 : \
    (`TBDCI_LOOP_NS / `TBDCI_CLK_NS))

`endif

// >>> tbdci_pkg.sv
package tbdci_pkg;

   typedef logic [8:0]  tbdci_level_t;
   typedef logic [2:0]  tbdci_code_t;
   typedef logic [15:0] tbdci_sel_t;

   typedef enum logic [1:0] {
      TBDCI_CH_RED   = 2'h0,
      TBDCI_CH_BLUE  = 2'h1,
      TBDCI_CH_GREEN = 2'h2
   } tbdci_chan_e;

endpackage : tbdci_pkg

// >>> tbdci_top.sv
`include "tbdci_defs.svh"

// Behaviour
// - retrace blanking forces mod and demod integrators to reference level
// - first sample after blanking integrates from the reference level
// - seven comparator lines priority-encoded; highest asserted line wins
// - code captured on word sample clock, delivered once per sample
// - code 111 is largest positive step, 011 largest negative step
// - each code selects a weight added to or subtracted from integrator
// - integrator holds its value without leakage between updates
// - whole modulator loop completes within one sample period, one 50 ns clock
// - modulator uses fixed step weights 3434, ignores selectable weights
// - 9-bit adder is carry-select: duplicated upper slices picked by carry
// - add or subtract chosen from the weight's most significant bit
// - sum stored each sample, fed back, and drives converter output
// - demodulator has three identical independent red, blue, green channels
// - demod code becomes signed form, then weighted by step converter
// - demod adds or subtracts weight with sum delayed one clock
// - weights are 9-bit sign-magnitude, msb set means negative
// - negative weight feeds complemented magnitude into the adder
// - negative add returns carry out into the sum (end-around carry)
// - stored sum uses offset unipolar coding for unipolar converter
module tbdci_top (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [6:0]  cmp_lines,
   input  wire logic        blank,
   input  wire logic [2:0]  dm_code_red,
   input  wire logic [2:0]  dm_code_blue,
   input  wire logic [2:0]  dm_code_green,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   output logic      [2:0]  mod_code_q,
   output logic             mod_code_valid_q,
   output logic      [8:0]  mod_dac_q,
   output logic      [8:0]  dm_dac_red,
   output logic      [8:0]  dm_dac_blue,
   output logic      [8:0]  dm_dac_green
);

   ////////////////////////////////////////////////////////////////////////
   // functions

   // priority encoder, then folded onto the modified binary step code
   function automatic tbdci_pkg::tbdci_code_t enc_code(
      input logic [6:0] lines
   );
      logic [2:0] lvl;
      lvl = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (lines[i]) begin
            lvl = 3'(i + 1);
         end
      end
      // upper half maps straight, lower half mirrors so 011 is deepest
      enc_code = lvl[2] ? lvl : {1'b0, ~lvl[1:0]};
   endfunction : enc_code

   // step code to 9-bit sign-magnitude weight
   function automatic tbdci_pkg::tbdci_level_t step_weight(
      input tbdci_pkg::tbdci_code_t code,
      input tbdci_pkg::tbdci_sel_t  sel
   );
      logic [7:0] mag;
      mag = {4'h0, sel[3:0]};
      if (code[1:0] >= 2'h1) begin
         mag = mag + {4'h0, sel[7:4]};
      end
      if (code[1:0] >= 2'h2) begin
         mag = mag + {4'h0, sel[11:8]};
      end
      if (code[1:0] == 2'h3) begin
         mag = mag + {4'h0, sel[15:12]};
      end
      // code bit 2 set is a positive step; weight msb set is negative
      step_weight = {~code[2], mag};
   endfunction : step_weight

   // carry-select 9-bit add, returns {carry, sum}
   function automatic logic [9:0] cs_add(
      input logic [8:0] a,
      input logic [8:0] b
   );
      logic [4:0] lo;
      logic [4:0] mid0;
      logic [4:0] mid1;
      logic [1:0] hi0;
      logic [1:0] hi1;
      logic [4:0] mid;
      logic [1:0] hi;
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      // both upper slices are computed ahead of the lower carry
      mid0 = {1'b0, a[7:4]} + {1'b0, b[7:4]};
      mid1 = {1'b0, a[7:4]} + {1'b0, b[7:4]} + 5'h01;
      hi0  = {1'b0, a[8]} + {1'b0, b[8]};
      hi1  = {1'b0, a[8]} + {1'b0, b[8]} + 2'h1;
      mid  = lo[4] ? mid1 : mid0;
      hi   = mid[4] ? hi1 : hi0;
      cs_add = {hi, mid[3:0], lo[3:0]};
   endfunction : cs_add

   // one integrator step in offset code, with end-around carry
   function automatic tbdci_pkg::tbdci_level_t integ(
      input tbdci_pkg::tbdci_level_t acc,
      input tbdci_pkg::tbdci_level_t w
   );
      logic [8:0] opnd;
      logic [9:0] s;
      logic [9:0] s2;
      // sign picks subtract; complemented magnitude needs the end-around carry fixup
      opnd = w[8] ? {1'b1, ~w[7:0]} : {1'b0, w[7:0]};
      s    = cs_add(acc, opnd);
      if (!w[8]) begin
         integ = s[9] ? `TBDCI_MAX_LEVEL : s[8:0];
      end else if (!s[9]) begin
         // no carry on subtract means the result fell to zero or below
         integ = `TBDCI_MIN_LEVEL;
      end else begin
         s2 = cs_add(s[8:0], 9'h001);
         integ = (s2[8:0] == 9'h000) ? `TBDCI_MIN_LEVEL : s2[8:0];
      end
   endfunction : integ

   ////////////////////////////////////////////////////////////////////////
   // word sample clock divider

   localparam int LOOP_CYC = `TBDCI_LOOP_CYC;

   logic [3:0] div_q;
   logic       word_sample_clock;

   // the loop closes in one clock, so the sample period never exceeds 80 ns
   assign word_sample_clock = (div_q == 4'(LOOP_CYC - 1));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         div_q <= 4'h0;
      end else if (word_sample_clock) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // modulator: encoder register and integrator

   tbdci_pkg::tbdci_code_t  mod_code_d;
   tbdci_pkg::tbdci_level_t mod_w;

   assign mod_code_d = enc_code(cmp_lines);
   // hard-wired weights, the control register never reaches this path
   assign mod_w = step_weight(mod_code_d, `TBDCI_MOD_SEL);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mod_code_q       <= `TBDCI_ZERO_CODE;
         mod_code_valid_q <= 1'b0;
      end else begin
         mod_code_valid_q <= word_sample_clock;
         if (word_sample_clock) begin
            mod_code_q <= mod_code_d;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         mod_dac_q <= `TBDCI_REF_LEVEL;
      end else if (blank) begin
         mod_dac_q <= `TBDCI_REF_LEVEL;
      end else if (word_sample_clock) begin
         // after blanking this starts from the reference level
         mod_dac_q <= integ(mod_dac_q, mod_w);
      end
      // otherwise the stored sum holds with no decay
   end

   ////////////////////////////////////////////////////////////////////////
   // demodulator: three identical channels

   tbdci_pkg::tbdci_sel_t   sel_q;
   tbdci_pkg::tbdci_level_t dm_acc_q [3];
   tbdci_pkg::tbdci_code_t  dm_code  [3];

   assign dm_code[tbdci_pkg::TBDCI_CH_RED]   = dm_code_red;
   assign dm_code[tbdci_pkg::TBDCI_CH_BLUE]  = dm_code_blue;
   assign dm_code[tbdci_pkg::TBDCI_CH_GREEN] = dm_code_green;

   for (genvar ch = 0; ch < 3; ch++) begin : g_demod
      tbdci_pkg::tbdci_level_t w;
      // weights track the selector, which must match the modulator
      assign w = step_weight(dm_code[ch], sel_q);

      always_ff @(posedge clk) begin
         if (!rst_b) begin
            dm_acc_q[ch] <= `TBDCI_REF_LEVEL;
         end else if (blank) begin
            dm_acc_q[ch] <= `TBDCI_REF_LEVEL;
         end else if (word_sample_clock) begin
            dm_acc_q[ch] <= integ(dm_acc_q[ch], w);
         end
      end
   end

   assign dm_dac_red   = dm_acc_q[tbdci_pkg::TBDCI_CH_RED];
   assign dm_dac_blue  = dm_acc_q[tbdci_pkg::TBDCI_CH_BLUE];
   assign dm_dac_green = dm_acc_q[tbdci_pkg::TBDCI_CH_GREEN];

   ////////////////////////////////////////////////////////////////////////
   // avalon-mm slave, one wait state on every access

   logic        req;
   logic        ack;
   logic [31:0] rdata_d;

   assign req = avs_read | avs_write;
   // ack is the cycle where waitrequest is low and the request is taken
   assign ack = req & ~avs_waitrequest;

   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address[3:2])
         2'h0: rdata_d[15:0] = sel_q;
         2'h1: begin
            rdata_d[`TBDCI_STAT_ACC_LSB +: 9]  = mod_dac_q;
            rdata_d[`TBDCI_STAT_CODE_LSB +: 3] = mod_code_q;
            rdata_d[`TBDCI_STAT_BLK_BIT]       = blank;
         end
         2'h2: begin
            rdata_d[8:0]   = dm_acc_q[tbdci_pkg::TBDCI_CH_RED];
            rdata_d[24:16] = dm_acc_q[tbdci_pkg::TBDCI_CH_BLUE];
         end
         2'h3: rdata_d[8:0] = dm_acc_q[tbdci_pkg::TBDCI_CH_GREEN];
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if (ack) begin
         avs_waitrequest <= 1'b1;
      end else if (req) begin
         avs_waitrequest <= 1'b0;
         avs_readdata    <= avs_read ? rdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sel_q <= `TBDCI_CTRL_RST;
      end else if (ack && avs_write &&
                   (avs_address == `TBDCI_REG_CTRL)) begin
         sel_q <= avs_writedata[`TBDCI_CTRL_SEL_MSB:`TBDCI_CTRL_SEL_LSB];
      end
   end

endmodule : tbdci_top

// >>> tbdci_sva.sv
module tbdci_sva (
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic [6:0] cmp_lines,
   input wire logic       blank,
   input wire logic [2:0] mod_code_q,
   input wire logic       mod_code_valid_q,
   input wire logic [8:0] mod_dac_q,
   input wire logic [8:0] dm_dac_red,
   input wire logic [8:0] dm_dac_green
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   reset_load_a: assert property (disable iff (1'b0) !rst_b |=>
      mod_code_q == 3'h4 && mod_dac_q == 9'h100 && !mod_code_valid_q)
      else $error("reset state wrong");
   blank_ref_a: assert property (blank |=> mod_dac_q == 9'h100 &&
      dm_dac_red == 9'h100 && dm_dac_green == 9'h100)
      else $error("blanking did not force reference");
   first_step_a: assert property (blank ##1 !blank |=>
      (mod_code_q[2] ? mod_dac_q inside {[9'h101:9'h10e]}
                     : mod_dac_q inside {[9'h0f2:9'h0ff]}))
      else $error("first sample not from reference");
   top_line_a: assert property (cmp_lines[6] |=> mod_code_q == 3'h7)
      else $error("highest line not encoded");
   no_line_a: assert property (cmp_lines == 7'h00 |=> mod_code_q == 3'h3)
      else $error("largest negative code wrong");
   per_sample_a: assert property (rst_b |=> mod_code_valid_q)
      else $error("sample strobe missing");
   add_step_a: assert property (!blank && cmp_lines[6] &&
      mod_dac_q <= 9'h1f1 |=> mod_dac_q == $past(mod_dac_q) + 9'd14)
      else $error("positive step wrong");
   sat_top_a: assert property (!blank && cmp_lines[6] &&
      mod_dac_q > 9'h1f1 |=> mod_dac_q == 9'h1ff)
      else $error("no saturation at top");
   sub_step_a: assert property (!blank && cmp_lines == 7'h00 &&
      mod_dac_q > 9'h00e |=> mod_dac_q == $past(mod_dac_q) - 9'd14)
      else $error("negative step wrong");
   sat_floor_a: assert property (!blank && cmp_lines == 7'h00 &&
      mod_dac_q <= 9'h00e |=> mod_dac_q == 9'h001)
      else $error("no saturation at floor");
   cover property (blank ##1 !blank);
   cover property (mod_dac_q == 9'h1ff);
   cover property (mod_dac_q == 9'h001);
endmodule : tbdci_sva
bind tbdci_top tbdci_sva u_sva (.clk(clk), .rst_b(rst_b),
   .cmp_lines(cmp_lines), .blank(blank), .mod_code_q(mod_code_q),
   .mod_code_valid_q(mod_code_valid_q), .mod_dac_q(mod_dac_q),
   .dm_dac_red(dm_dac_red), .dm_dac_green(dm_dac_green));

// >>> tbdci_front.sv
module tbdci_front (
   input  wire logic signed [10:0] video,
   input  wire logic        [8:0]  dac,
   output logic             [6:0]  lines
);
   timeunit 1ns;
   timeprecision 1ns;
   // thresholds midway between steps 4/7/11/14, so lines form a thermometer
   localparam int TH[7] = '{-12, -9, -5, 0, 5, 9, 12};
   always_comb begin
      for (int k = 0; k < 7; k++) begin
         lines[k] = (int'(video) - int'(dac)) > TH[k];
      end
   end
endmodule : tbdci_front

// >>> tbdci_tb_top.sv
module tbdci_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk = 1'b0, rst_b = 1'b0, blank = 1'b1;
   logic               use_rand = 1'b1, chk_on = 1'b0;
   logic        [6:0]  rnd = 7'h00;
   logic        [2:0]  dmc [3] = '{3'h4, 3'h4, 3'h4};
   logic        [3:0]  avs_address = 4'h0;
   logic               avs_read = 1'b0, avs_write = 1'b0;
   logic        [31:0] avs_writedata = 32'h0, q, wd;
   logic signed [10:0] video = 11'h000;
   logic        [15:0] m_sel;
   logic        [31:0] avs_readdata;
   logic               avs_waitrequest, mod_code_valid_q;
   logic        [2:0]  mod_code_q;
   logic        [8:0]  mod_dac_q, dmo [3];
   logic        [6:0]  lines_fe;
   int                 errors = 0, comparisons = 0, seed = 7608;
   int                 m_code, m_vld, m_mod, m_dm [3];
   int                 vt [4] = '{600, -100, 320, 192};
   wire logic   [6:0]  cmp = use_rand ? rnd : lines_fe;
   always #25 clk = ~clk;
   tbdci_front u_front (.video(video), .dac(mod_dac_q), .lines(lines_fe));
   tbdci_top uut (
      .clk(clk), .rst_b(rst_b), .cmp_lines(cmp), .blank(blank),
      .dm_code_red(dmc[0]), .dm_code_blue(dmc[1]), .dm_code_green(dmc[2]),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mod_code_q(mod_code_q), .mod_code_valid_q(mod_code_valid_q),
      .mod_dac_q(mod_dac_q), .dm_dac_red(dmo[0]), .dm_dac_blue(dmo[1]),
      .dm_dac_green(dmo[2]));
   //////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) errors++;
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (w && a[3:2] == 2'h0) m_sel <= d[15:0];
   endtask : bus
   task automatic end_sim;
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   function automatic int wgt(input logic [2:0] c, input logic [15:0] s);
      int m;
      m = s[3:0];
      if (c[1:0] > 2'h0) m += s[7:4];
      if (c[1:0] > 2'h1) m += s[11:8];
      if (c[1:0] > 2'h2) m += s[15:12];
      return c[2] ? m : -m;
   endfunction : wgt
   // signed int math here: an unsigned limit would turn negative sums huge
   function automatic int step(input int a, input int w);
      return (a + w > 511) ? 511 : (a + w < 1) ? 1 : a + w;
   endfunction : step
   function automatic logic [2:0] enc(input logic [6:0] l);
      int h;
      h = 0;
      for (int i = 0; i < 7; i++) if (l[i]) h = i + 1;
      return (h >= 4) ? 3'(h) : {1'b0, ~2'(h)};
   endfunction : enc
   //////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (!rst_b) begin
         m_code <= 4;
         m_vld <= 0;
         m_mod <= 256;
         m_sel <= 16'h3434;
         foreach (m_dm[i]) m_dm[i] <= 256;
      end else begin
         m_code <= enc(cmp);
         m_vld <= 1;
         m_mod <= blank ? 256 : step(m_mod, wgt(enc(cmp), 16'h3434));
         foreach (m_dm[i]) m_dm[i] <= blank ? 256 :
            step(m_dm[i], wgt(dmc[i], m_sel));
      end
   end
   always @(negedge clk) if (chk_on) begin
      chk("mod_code_q", m_code, mod_code_q);
      chk("mod_code_valid_q", m_vld, mod_code_valid_q);
      chk("mod_dac_q", m_mod, mod_dac_q);
      foreach (dmo[i]) chk("dm_dac", m_dm[i], dmo[i]);
   end
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      end_sim();
   end
   initial begin
      @(posedge clk);
      chk_on <= 1'b1;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl", 32'h3434, q & 32'hffff);
      bus(1'b1, 4'h4, 32'hffff);
      bus(1'b1, 4'h8, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl_ro", 32'h3434, q & 32'hffff);
      bus(1'b0, 4'h8, 32'h0);
      chk("red_blue", 32'h01000100, q & 32'h01ff01ff);
      bus(1'b0, 4'hc, 32'h0);
      chk("green", 32'h100, q & 32'h1ff);
      bus(1'b0, 4'h4, 32'h0);
      chk("status", 32'h100100, q & 32'h1001ff);
      wd = $random(seed);
      bus(1'b1, 4'h0, wd);
      bus(1'b0, 4'h0, 32'h0);
      chk("ctrl_rw", wd & 32'hffff, q & 32'hffff);
      for (int n = 0; n < 300; n++) begin
         @(posedge clk);
         rnd <= 7'($random(seed));
         blank <= ($random(seed) & 7) == 0;
         rst_b <= !(n == 150 || n == 151);
         foreach (dmc[i]) dmc[i] <= 3'($random(seed));
      end
      bus(1'b1, 4'h0, 32'h3434);
      use_rand <= 1'b0;
      blank <= 1'b1;
      repeat (3) @(posedge clk);
      blank <= 1'b0;
      // field memory echoes the modulator code into the red channel
      foreach (vt[i]) begin
         video <= 11'(vt[i]);
         repeat (60) begin
            @(posedge clk);
            dmc[0] <= mod_code_q;
         end
      end
      blank <= 1'b1;
      @(posedge clk);
      blank <= 1'b0;
      repeat (10) @(posedge clk);
      end_sim();
   end
endmodule : tbdci_tb_top
